// *** design/gpa_pkg.sv ***
// Purpose: shared constants and types for the port A pin control block
// Assumes: one 20 MHz system clock, synchronous active-high reset
// Notes: register selects are local encodings used on the core-side ports
package gpa_pkg;
    localparam int GPA_PINS = 8;
    localparam int GPA_ANALOG_PINS = 6;
    localparam int GPA_SYNC_STAGES = 2;

    // reset values of the configuration registers
    localparam logic [7:0] GPA_DIR_RST = 8'hff;
    localparam logic [7:0] GPA_LAT_RST = 8'h00;
    localparam logic [7:0] GPA_OD_RST = 8'h00;
    localparam logic [7:0] GPA_SLR_RST = 8'hff;
    localparam logic [7:0] GPA_THR_RST = 8'h00;
    localparam logic [7:0] GPA_ANS_RST = 8'h3f;
    localparam logic [7:0] GPA_WPU_RST = 8'hff;

    // implemented analog-select bits, upper two read as zero
    localparam logic [7:0] GPA_ANS_MASK = 8'h3f;
    localparam logic [7:0] GPA_ALL_BITS = 8'hff;

    // register selects seen on the core-side access ports
    typedef enum logic [2:0] {
        GPA_SEL_DIRECTION,
        GPA_SEL_PIN_LEVEL,
        GPA_SEL_OUT_LATCH,
        GPA_SEL_OPEN_DRAIN,
        GPA_SEL_SLEW,
        GPA_SEL_THRESHOLD,
        GPA_SEL_ANALOG,
        GPA_SEL_PULLUP
    } gpa_sel_t;
endpackage : gpa_pkg

// *** design/gpa_in_sync.sv ***
// Purpose: per-pin input threshold choice, synchroniser and change detect
// Assumes: pad supplies both a schmitt and a ttl comparator output per pin
// Notes: analog pins read zero and never report a change
module gpa_in_sync
    import gpa_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic [7:0] pad_in_st, // schmitt comparator outputs
    input wire logic [7:0] pad_in_ttl, // ttl comparator outputs
    input wire logic [7:0] thresh_sel, // 1 schmitt, 0 ttl
    input wire logic [7:0] analog_sel, // 1 analog, digital buffer off
    output logic [7:0] level, // synchronised digital level
    output logic [7:0] change // one-cycle pulse on level change
);
    logic [7:0] stage1_reg;
    logic [7:0] stage2_reg;
    logic [7:0] prev_reg;
    logic [7:0] raw;

    genvar i;
    generate
        for (i = 0; i < GPA_PINS; i++)
        begin : g_pin
            // threshold picks the comparator for reads and change detect
            // threshold governs both
            assign raw[i] = thresh_sel[i] ? pad_in_st[i] : pad_in_ttl[i];
        end
    endgenerate

    // two-stage synchroniser, then a history stage for edges
    // two-stage synchroniser
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stage1_reg <= 8'h00;
            stage2_reg <= 8'h00;
            prev_reg <= 8'h00;
        end
        else
        begin
            stage1_reg <= raw;
            stage2_reg <= stage1_reg;
            prev_reg <= level;
        end
    end

    // analog pins have their digital buffer disabled
    // analog reads zero
    assign level = stage2_reg & ~(analog_sel & GPA_ANS_MASK);
    // masked so that moving a pin into analog mode raises no pulse
    // no analog change
    assign change = (level ^ prev_reg) & ~(analog_sel & GPA_ANS_MASK);
endmodule : gpa_in_sync

// *** design/gpa_port.sv ***
// Purpose: eight-pin bidirectional port with direction, latch and pad controls
// Assumes: core writes through wr_en/wr_sel, reads through rd_en/rd_sel
// Notes: read data and all pad controls come from flops, one cycle late
//
// Functional notes
// - eight pins, each with own direction, latch, drive, threshold bits; analog bits on six.
// - direction one disables driver; zero drives the latch value.
// - pin-level read returns pin levels; pin-level write updates latch.
// - latch write equals pin-level write; latch read returns held latch.
// - port writes read pins, modify addressed bits, store into latch.
// - open-drain bit set means sink only, never drive high.
// - slew bit set asserts the pad slew-limit control.
// - threshold choice governs pin reads and change detection.
// - analog-select set disables digital buffer; digital reads return zero.
// - analog select never affects digital output drive.
// - direction still controls drivers on analog pins; software keeps it set.
// - analog-select bits reset to analog; software clears them for digital.
// - enabled peripheral overrides latch output, pin stays readable.
// - only six low pins have analog select; upper two read zero.
// - threshold bit one selects schmitt, zero selects ttl.
// - pull-up on only if bit set, global disable clear, not output.
module gpa_port
    import gpa_pkg::*;
(
    input wire logic clk, // system clock, 20 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic wr_en, // register write strobe
    input wire gpa_sel_t wr_sel, // register written
    input wire logic [7:0] wr_data, // write data
    input wire logic [7:0] wr_mask, // bits addressed by the write
    input wire logic rd_en, // register read strobe
    input wire gpa_sel_t rd_sel, // register read
    output logic [7:0] rd_data, // read data, valid cycle after rd_en
    input wire logic pullup_global_disable, // 1 turns off every pull-up
    input wire logic [7:0] periph_en, // peripheral owns the pin output
    input wire logic [7:0] periph_out, // peripheral output value
    input wire logic [7:0] pad_in_st, // pin level, schmitt thresholds
    input wire logic [7:0] pad_in_ttl, // pin level, ttl thresholds
    output logic [7:0] pad_out, // pin output value
    output logic [7:0] pad_oe, // pin output enable, high drives
    output logic [7:0] pad_slew_limit, // pad slew limiting on
    output logic [7:0] pad_pullup, // weak pull-up on
    output logic [7:0] pad_schmitt, // pad threshold select
    output logic [7:0] pad_dig_in_en, // digital input buffer on
    output logic [7:0] pin_change // one-cycle pulse per changed pin
);
    logic [7:0] direction_reg;
    logic [7:0] output_latch_reg;
    logic [7:0] open_drain_reg;
    logic [7:0] slew_limit_reg;
    logic [7:0] input_threshold_reg;
    logic [7:0] analog_select_reg;
    logic [7:0] pullup_enable_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] pad_out_reg;
    logic [7:0] pad_oe_reg;
    logic [7:0] pad_slew_reg;
    logic [7:0] pad_pullup_reg;
    logic [7:0] pad_schmitt_reg;
    logic [7:0] pad_dig_in_reg;
    logic [7:0] pin_change_reg;
    logic [7:0] pin_level;
    logic [7:0] level_change;
    logic [7:0] latch_next;
    logic [7:0] rd_data_next;
    logic [7:0] drive_val;
    logic [7:0] oe_next;
    logic [7:0] out_next;
    logic [7:0] pullup_next;
    logic port_write;

    // synchronised, threshold-selected and analog-masked pin levels
    gpa_in_sync u_in_sync (
        .clk(clk),
        .srst(srst),
        .pad_in_st(pad_in_st),
        .pad_in_ttl(pad_in_ttl),
        .thresh_sel(input_threshold_reg),
        .analog_sel(analog_select_reg),
        .level(pin_level),
        .change(level_change)
    );

    // latch and pin-level selects both write the latch
    // same write effect
    assign port_write = wr_en && (wr_sel == GPA_SEL_PIN_LEVEL || wr_sel == GPA_SEL_OUT_LATCH);

    // read-modify-write: unaddressed bits take the current pin levels
    // read-modify-write merge
    assign latch_next = (pin_level & ~wr_mask) | (wr_data & wr_mask);

    // output latch
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            output_latch_reg <= GPA_LAT_RST;
        end
        else if (port_write)
        begin
            output_latch_reg <= latch_next;
        end
    end

    // direction register, input after reset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            direction_reg <= GPA_DIR_RST;
        end
        else if (wr_en && wr_sel == GPA_SEL_DIRECTION)
        begin
            direction_reg <= (direction_reg & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    // drive-mode, slew and threshold registers
    // per-pin control bits
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            open_drain_reg <= GPA_OD_RST;
            slew_limit_reg <= GPA_SLR_RST;
            input_threshold_reg <= GPA_THR_RST;
        end
        else if (wr_en)
        begin
            if (wr_sel == GPA_SEL_OPEN_DRAIN)
            begin
                open_drain_reg <= (open_drain_reg & ~wr_mask) | (wr_data & wr_mask);
            end
            else if (wr_sel == GPA_SEL_SLEW)
            begin
                slew_limit_reg <= (slew_limit_reg & ~wr_mask) | (wr_data & wr_mask);
            end
            else if (wr_sel == GPA_SEL_THRESHOLD)
            begin
                input_threshold_reg <= (input_threshold_reg & ~wr_mask) | (wr_data & wr_mask);
            end
        end
    end

    // analog select and pull-up enables
    // reset to analog
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            analog_select_reg <= GPA_ANS_RST;
            pullup_enable_reg <= GPA_WPU_RST;
        end
        else if (wr_en)
        begin
            if (wr_sel == GPA_SEL_ANALOG)
            begin
                analog_select_reg <= ((analog_select_reg & ~wr_mask) | (wr_data & wr_mask))
                    & GPA_ANS_MASK;
            end
            else if (wr_sel == GPA_SEL_PULLUP)
            begin
                pullup_enable_reg <= (pullup_enable_reg & ~wr_mask) | (wr_data & wr_mask);
            end
        end
    end

    // read multiplexer, address decode by if chain
    always_comb
    begin
        rd_data_next = 8'h00;
        if (rd_sel == GPA_SEL_DIRECTION)
        begin
            rd_data_next = direction_reg;
        end
        else if (rd_sel == GPA_SEL_PIN_LEVEL)
        begin
            rd_data_next = pin_level;
        end
        else if (rd_sel == GPA_SEL_OUT_LATCH)
        begin
            rd_data_next = output_latch_reg;
        end
        else if (rd_sel == GPA_SEL_OPEN_DRAIN)
        begin
            rd_data_next = open_drain_reg;
        end
        else if (rd_sel == GPA_SEL_SLEW)
        begin
            rd_data_next = slew_limit_reg;
        end
        else if (rd_sel == GPA_SEL_THRESHOLD)
        begin
            rd_data_next = input_threshold_reg;
        end
        else if (rd_sel == GPA_SEL_ANALOG)
        begin
            rd_data_next = analog_select_reg & GPA_ANS_MASK;
        end
        else
        begin
            rd_data_next = pullup_enable_reg;
        end
    end

    // read data holds until the next read
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_data_reg <= 8'h00;
        end
        else if (rd_en)
        begin
            rd_data_reg <= rd_data_next;
        end
    end

    // output source: peripheral overrides the latch when enabled
    // peripheral owns output
    assign drive_val = (periph_en & periph_out) | (~periph_en & output_latch_reg);

    // driver enable: direction rules, analog select plays no part
    // direction gates driver
    assign oe_next = ~direction_reg & ~(open_drain_reg & drive_val);
    assign out_next = drive_val & ~open_drain_reg;

    // pull-up only on non-output pins with global enable
    // pull-up gating
    assign pullup_next = pullup_enable_reg & direction_reg & {GPA_PINS{~pullup_global_disable}};

    // registered pad controls
    // slew limit out
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pad_out_reg <= 8'h00;
            pad_oe_reg <= 8'h00;
            pad_slew_reg <= GPA_SLR_RST;
            pad_pullup_reg <= 8'h00;
            pad_schmitt_reg <= GPA_THR_RST;
            pad_dig_in_reg <= ~GPA_ANS_RST;
            pin_change_reg <= 8'h00;
        end
        else
        begin
            pad_out_reg <= out_next;
            pad_oe_reg <= oe_next;
            pad_slew_reg <= slew_limit_reg;
            pad_pullup_reg <= pullup_next;
            pad_schmitt_reg <= input_threshold_reg;
            pad_dig_in_reg <= ~(analog_select_reg & GPA_ANS_MASK);
            pin_change_reg <= level_change;
        end
    end

    assign rd_data = rd_data_reg;
    assign pad_out = pad_out_reg;
    assign pad_oe = pad_oe_reg;
    assign pad_slew_limit = pad_slew_reg;
    assign pad_pullup = pad_pullup_reg;
    assign pad_schmitt = pad_schmitt_reg;
    assign pad_dig_in_en = pad_dig_in_reg;
    assign pin_change = pin_change_reg;
endmodule : gpa_port

// *** tb/gpa_port_props.sv ***
// Purpose: port assertions for the pin control block
// Assumes: one clock, synchronous reset
// Notes: bound to every gpa_port instance
module gpa_port_props
    import gpa_pkg::*;
(
    input wire logic clk, // clock
    input wire logic srst, // reset
    input wire logic wr_en, // write
    input wire gpa_sel_t wr_sel, // write select
    input wire logic [7:0] wr_data, // data
    input wire logic [7:0] wr_mask, // mask
    input wire logic rd_en, // read
    input wire gpa_sel_t rd_sel, // read select
    input wire logic [7:0] rd_data, // read data
    input wire logic pullup_global_disable, // pull-ups off
    input wire logic [7:0] pad_out, // drive value
    input wire logic [7:0] pad_oe, // drive enable
    input wire logic [7:0] pad_slew_limit, // slew
    input wire logic [7:0] pad_pullup, // pull-up
    input wire logic [7:0] pad_schmitt, // threshold
    input wire logic [7:0] pad_dig_in_en // input buffer
);
    timeunit 1ns;
    timeprecision 1ns;
    logic full;
    logic an_wr;
    // whole-byte write and analog write strobes
    assign full = wr_en && wr_mask == 8'hff;
    assign an_wr = wr_en && wr_sel == GPA_SEL_ANALOG;
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    // pad controls two edges after a write, reads one after the strobe
    dir_off_a: assert property (full && wr_sel == GPA_SEL_DIRECTION && wr_data == 8'hff
        |=> ##1 pad_oe == 8'h00) else $error("driver on after input select");
    od_low_a: assert property (full && wr_sel == GPA_SEL_OPEN_DRAIN && wr_data == 8'hff
        |=> ##1 pad_out == 8'h00) else $error("open drain drives high");
    slew_ctl_a: assert property (full && wr_sel == GPA_SEL_SLEW
        |=> ##1 pad_slew_limit == $past(wr_data, 2)) else $error("slew control wrong");
    thresh_sel_a: assert property (full && wr_sel == GPA_SEL_THRESHOLD
        |=> ##1 pad_schmitt == $past(wr_data, 2)) else $error("threshold wrong");
    latch_read_a: assert property (full && wr_sel == GPA_SEL_OUT_LATCH ##1 !wr_en
        ##1 rd_en && rd_sel == GPA_SEL_OUT_LATCH && !wr_en |=> rd_data == $past(wr_data, 3))
        else $error("latch read wrong");
    analog_zero_a: assert property (rd_en && rd_sel == GPA_SEL_PIN_LEVEL && !an_wr
        && !$past(an_wr) |=> (rd_data & ~pad_dig_in_en) == 8'h00)
        else $error("analog pin read high");
    upper_buf_a: assert property (pad_dig_in_en[7:6] == 2'b11)
        else $error("upper input buffer off");
    pullup_gate_a: assert property (pad_pullup != 8'h00
        |-> !$past(pullup_global_disable) && (pad_pullup & pad_oe) == 8'h00)
        else $error("pull-up on when barred");
endmodule : gpa_port_props

bind gpa_port gpa_port_props i_props (.clk(clk), .srst(srst), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .wr_mask(wr_mask), .rd_en(rd_en),
    .rd_sel(rd_sel), .rd_data(rd_data), .pullup_global_disable(pullup_global_disable),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_slew_limit(pad_slew_limit),
    .pad_pullup(pad_pullup), .pad_schmitt(pad_schmitt), .pad_dig_in_en(pad_dig_in_en));

// *** tb/gpa_pins_model.sv ***
// Purpose: pins and board model beside the port
// Assumes: board drivers yield to the port's own drivers
// Notes: mid marks a pin between the two thresholds
module gpa_pins_model (
    input wire logic clk, // clock
    input wire logic [7:0] pad_out, // port value
    input wire logic [7:0] pad_oe, // port drives
    input wire logic [7:0] pad_pullup, // weak pull-up
    input wire logic [7:0] ext_val, // board value
    input wire logic [7:0] ext_en, // board drives
    input wire logic [7:0] ext_mid, // mid level pins
    output logic [7:0] pad_in_st, // schmitt view
    output logic [7:0] pad_in_ttl // ttl view
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lvl;
    logic [7:0] float_reg = 8'h00;
    assign lvl = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
        | (~pad_oe & ~ext_en & (pad_pullup | float_reg));
    // undriven pins without pull-up flip every cycle
    always @(posedge clk)
        float_reg <= ~lvl;
    // mid level reads high on ttl, low on schmitt
    assign pad_in_st = lvl & ~ext_mid;
    assign pad_in_ttl = lvl | ext_mid;
endmodule : gpa_pins_model

// *** tb/gpa_port_test.sv ***
// Purpose: self-checking bench for the port pin control block
// Assumes: 50 ns clock, inputs driven on the falling edge
// Notes: pin levels come from the pins model
module gpa_port_test
    import gpa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic pullup_global_disable = 1'b0;
    gpa_sel_t wr_sel = GPA_SEL_DIRECTION;
    gpa_sel_t rd_sel = GPA_SEL_DIRECTION;
    logic [7:0] wr_data = 8'h00, wr_mask = 8'h00, periph_en = 8'h00, periph_out = 8'h00;
    logic [7:0] ext_val = 8'hff, ext_en = 8'hff, ext_mid = 8'h00;
    logic [7:0] rd_data, pad_in_st, pad_in_ttl, pad_out, pad_oe, pad_slew_limit;
    logic [7:0] pad_pullup, pad_schmitt, pad_dig_in_en, pin_change;
    logic [7:0] rst_vals [8] = '{8'hff, 8'hc0, 8'h00, 8'h00, 8'hff, 8'h00, 8'h3f, 8'hff};
    int fails = 0;
    int num_checks = 0;
    // 20 MHz clock
    always #25 clk = ~clk;
    gpa_port i_dut (.clk(clk), .srst(srst), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_data(wr_data), .wr_mask(wr_mask), .rd_en(rd_en), .rd_sel(rd_sel),
        .rd_data(rd_data), .pullup_global_disable(pullup_global_disable),
        .periph_en(periph_en), .periph_out(periph_out), .pad_in_st(pad_in_st),
        .pad_in_ttl(pad_in_ttl), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_slew_limit(pad_slew_limit), .pad_pullup(pad_pullup),
        .pad_schmitt(pad_schmitt), .pad_dig_in_en(pad_dig_in_en), .pin_change(pin_change));
    gpa_pins_model i_pins (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_val(ext_val), .ext_en(ext_en), .ext_mid(ext_mid),
        .pad_in_st(pad_in_st), .pad_in_ttl(pad_in_ttl));
    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // wait falling edges
    task automatic nc(input int n);
        repeat (n) @(negedge clk);
    endtask : nc
    // one write cycle, then an idle cycle
    task automatic wr(input gpa_sel_t s, input logic [7:0] d, input logic [7:0] m);
        wr_en = 1'b1;
        wr_sel = s;
        wr_data = d;
        wr_mask = m;
        nc(1);
        wr_en = 1'b0;
        nc(1);
    endtask : wr
    // one read cycle with compare
    task automatic rd(input gpa_sel_t s, input logic [7:0] exp);
        rd_en = 1'b1;
        rd_sel = s;
        nc(1);
        rd_en = 1'b0;
        chk(rd_data, exp);
        nc(1);
    endtask : rd
    // print verdict and stop
    task automatic end_sim;
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    // main sequence
    initial
    begin
        nc(16);
        srst = 1'b0;
        nc(4);
        for (int i = 0; i < 8; i++)
            rd(gpa_sel_t'(i), rst_vals[i]);
        chk(pad_dig_in_en, 8'hc0);
        chk(pad_slew_limit, 8'hff);
        wr(GPA_SEL_ANALOG, 8'hff, 8'hff);
        rd(GPA_SEL_ANALOG, 8'h3f);
        wr(GPA_SEL_ANALOG, 8'h00, 8'hff);
        ext_val = 8'h00;
        ext_mid = 8'h0f;
        nc(4);
        rd(GPA_SEL_PIN_LEVEL, 8'h0f);
        wr(GPA_SEL_THRESHOLD, 8'hff, 8'hff);
        chk(pad_schmitt, 8'hff);
        nc(4);
        rd(GPA_SEL_PIN_LEVEL, 8'h00);
        ext_mid = 8'h00;
        nc(4);
        ext_val = 8'h01;
        nc(3);
        chk(pin_change, 8'h01);
        nc(1);
        chk(pin_change, 8'h00);
        wr(GPA_SEL_DIRECTION, 8'h00, 8'hff);
        wr(GPA_SEL_OUT_LATCH, 8'h5a, 8'hff);
        chk(pad_oe, 8'hff);
        chk(pad_out, 8'h5a);
        rd(GPA_SEL_OUT_LATCH, 8'h5a);
        nc(4);
        rd(GPA_SEL_PIN_LEVEL, 8'h5a);
        wr(GPA_SEL_DIRECTION, 8'hf0, 8'hff);
        ext_val = 8'h3c;
        nc(4);
        wr(GPA_SEL_PIN_LEVEL, 8'h00, 8'h0f);
        rd(GPA_SEL_OUT_LATCH, 8'h30);
        wr(GPA_SEL_OUT_LATCH, 8'h0f, 8'h0f);
        rd(GPA_SEL_OUT_LATCH, 8'h3f);
        wr(GPA_SEL_DIRECTION, 8'h00, 8'hff);
        wr(GPA_SEL_OPEN_DRAIN, 8'hff, 8'hff);
        chk(pad_out, 8'h00);
        chk(pad_oe, 8'hc0);
        wr(GPA_SEL_OPEN_DRAIN, 8'h00, 8'hff);
        wr(GPA_SEL_OUT_LATCH, 8'hc5, 8'hff);
        wr(GPA_SEL_ANALOG, 8'hff, 8'hff);
        chk(pad_out, 8'hc5);
        chk(pad_oe, 8'hff);
        nc(4);
        rd(GPA_SEL_PIN_LEVEL, 8'hc0);
        periph_en = 8'hff;
        periph_out = 8'ha5;
        nc(1);
        chk(pad_out, 8'ha5);
        nc(4);
        rd(GPA_SEL_PIN_LEVEL, 8'h80);
        rd(GPA_SEL_OUT_LATCH, 8'hc5);
        periph_en = 8'h00;
        wr(GPA_SEL_ANALOG, 8'h00, 8'hff);
        chk(pad_dig_in_en, 8'hff);
        wr(GPA_SEL_DIRECTION, 8'h0f, 8'hff);
        ext_en = 8'h00;
        chk(pad_pullup, 8'h0f);
        chk(pad_oe, 8'hf0);
        nc(4);
        rd(GPA_SEL_PIN_LEVEL, 8'hcf);
        pullup_global_disable = 1'b1;
        nc(1);
        chk(pad_pullup, 8'h00);
        wr(GPA_SEL_SLEW, 8'h00, 8'hff);
        chk(pad_slew_limit, 8'h00);
        wr(GPA_SEL_DIRECTION, 8'hff, 8'hff);
        chk(pad_oe, 8'h00);
        end_sim;
    end
    // watchdog against a hang
    initial
    begin
        repeat (4000) @(posedge clk);
        fails++;
        end_sim;
    end
endmodule : gpa_port_test
